//--- core/sar_adc_host_handshake.sv
`timescale 1ns/1ps
`default_nettype none
module sar_adc_host_handshake
  import sar_adc_pkg::*;
#(
  parameter int unsigned BIT_CYC = BIT_CYC_DEF
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Host control
  input wire logic cs_n_i,
  input wire logic wr_n_i,
  input wire logic rd_n_i,
  output logic conversion_done_n_o,
  // Host data bus
  output logic [sar_adc_pkg::RES_BITS-1:0] result_bus_o,
  output logic result_bus_oe_o,
  // Comparator front end
  output logic [sar_adc_pkg::RES_BITS-1:0] trial_code_o,
  input wire logic cmp_above_i,
  input wire logic neg_ge_pos_i
);
  import sar_adc_pkg::*;

  // ==========================================================
  // Parameter checks
  // Bit index is three bits wide, so only an eight-bit result fits
  if (RES_BITS != 8) begin : g_bad_res
    $error("RES_BITS must be 8");
  end
  if (BIT_CYC < 1) begin : g_bad_short
    $error("BIT_CYC must be at least 1");
  end
  // Conversion must fit the guaranteed maximum
  if (BIT_CYC * RES_BITS > MAX_CYC) begin : g_bad_long
    $error("BIT_CYC too long for the maximum conversion time");
  end

  // LATCH gives the result a cycle to settle before the flag falls
  typedef enum logic [1:0] {IDLE, ARMED, CONVERT, LATCH} state_e;

  localparam int unsigned CW = $clog2(BIT_CYC + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(BIT_CYC - 1);
  localparam logic [CW-1:0] CNT_ZERO = '0;
  localparam logic [2:0] BIT_TOP = 3'(RES_BITS - 1);

  // ==========================================================
  // Helper functions
  // Strobes count only while the chip is selected
  function automatic logic strobe_on(input logic sel_n, input logic strobe_n);
    return !sel_n && !strobe_n;
  endfunction : strobe_on

  function automatic logic count_done(input logic [CW-1:0] cnt);
    return cnt == CNT_LAST;
  endfunction : count_done

  function automatic logic is_last_bit(input logic [2:0] idx);
    return idx == 3'h0;
  endfunction : is_last_bit

  // Forced zero wins over whatever the trials resolved
  function automatic logic [RES_BITS-1:0] final_code(input logic zero_seen,
    input logic [RES_BITS-1:0] code);
    return zero_seen ? ZERO_CODE : code;
  endfunction : final_code

  // ==========================================================
  // Strobe qualification
  logic wr_q;
  logic wr_d;
  logic wr_fall;
  logic wr_rise;
  logic rd_act;

  always_comb begin
    wr_d = strobe_on(cs_n_i, wr_n_i);
    wr_fall = wr_d && !wr_q;
    // Rise with chip select high is not a start
    wr_rise = !wr_d && wr_q && !cs_n_i;
    rd_act = strobe_on(cs_n_i, rd_n_i);
  end

  // ==========================================================
  // Conversion sequencer
  state_e state_q;
  state_e state_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic [2:0] bit_q;
  logic [2:0] bit_d;
  logic [RES_BITS-1:0] sar_q;
  logic [RES_BITS-1:0] sar_d;
  // Result latch keeps its value across an aborted conversion
  logic [RES_BITS-1:0] result_q;
  logic [RES_BITS-1:0] result_d;
  logic done_n_q;
  logic done_n_d;
  logic oe_q;
  logic oe_d;
  logic zero_q;
  logic zero_d;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    bit_d = bit_q;
    sar_d = sar_q;
    result_d = result_q;
    done_n_d = done_n_q;
    zero_d = zero_q;
    oe_d = rd_act;
    case (state_q)
      IDLE, ARMED, LATCH: begin
        if (state_q == LATCH) begin
          // Flag falls one cycle after the latch is loaded
          done_n_d = 1'b0;
          state_d = IDLE;
        end
        if (wr_fall) begin
          done_n_d = 1'b1;
          state_d = ARMED;
        end else if (wr_rise && state_q == ARMED) begin
          // A stray rise without a seen fall does nothing
          state_d = CONVERT;
          sar_d = MSB_ONLY;
          bit_d = BIT_TOP;
          cnt_d = CNT_ZERO;
          zero_d = 1'b0;
        end
      end
      CONVERT: begin
        if (wr_fall) begin
          // A new write aborts and re-arms
          done_n_d = 1'b1;
          state_d = ARMED;
        end else if (count_done(cnt_q)) begin
          cnt_d = CNT_ZERO;
          if (neg_ge_pos_i) begin
            zero_d = 1'b1;
          end
          if (!cmp_above_i) begin
            sar_d[bit_q] = 1'b0;
          end
          if (is_last_bit(bit_q)) begin
            state_d = LATCH;
            result_d = final_code(zero_q || neg_ge_pos_i, sar_d);
          end else begin
            bit_d = bit_q - 3'h1;
            sar_d[bit_q - 3'h1] = 1'b1;
          end
        end else begin
          // Each trial bit gets BIT_CYC cycles for the comparator to settle
          cnt_d = cnt_q + CW'(1);
        end
      end
      default: begin
        state_d = IDLE;
      end
    endcase
    if (rd_act) begin
      // Set wins: a flag falling this cycle is not lost to the read
      if (!(state_q == LATCH && !wr_fall)) begin
        done_n_d = 1'b1;
      end
    end
  end

  // ==========================================================
  // State registers
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= IDLE;
      cnt_q <= '0;
      bit_q <= 3'h0;
      sar_q <= ZERO_CODE;
      result_q <= RESULT_RST;
      done_n_q <= 1'b1;
      oe_q <= 1'b0;
      zero_q <= 1'b0;
      wr_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      bit_q <= bit_d;
      sar_q <= sar_d;
      result_q <= result_d;
      done_n_q <= done_n_d;
      oe_q <= oe_d;
      zero_q <= zero_d;
      wr_q <= wr_d;
    end
  end

  // ==========================================================
  // Outputs
  // Every output is a plain copy of a register
  always_comb begin
    conversion_done_n_o = done_n_q;
    result_bus_o = result_q;
    result_bus_oe_o = oe_q;
    trial_code_o = sar_q;
  end

endmodule : sar_adc_host_handshake
`default_nettype wire

//--- core/sar_adc_pkg.sv
package sar_adc_pkg;
  // ==========================================================
  // Resolution and codes
  localparam int unsigned RES_BITS = 8;
  localparam logic [RES_BITS-1:0] ZERO_CODE = 8'h00;
  localparam logic [RES_BITS-1:0] MSB_ONLY = 8'h80;
  localparam logic [RES_BITS-1:0] RESULT_RST = 8'h00;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CONV_TYP_US = 30;
  localparam int unsigned CONV_TESTED_US = 40;
  localparam int unsigned CONV_MAX_US = 60;
  // Cycles per trial bit: whole conversion stays inside the typical figure
  localparam int unsigned CONV_TYP_CYC = CONV_TYP_US * (CLK_HZ / 1_000_000);
  localparam int unsigned BIT_CYC_DEF = CONV_TYP_CYC / RES_BITS;
  localparam int unsigned MAX_CYC = CONV_MAX_US * (CLK_HZ / 1_000_000);
endpackage : sar_adc_pkg

//--- test/comparator_model.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// Ideal comparator
module comparator_model (
  input wire logic [7:0] trial_code_i,
  input wire logic [7:0] level_i,
  output logic above_o
);
  assign above_o = level_i >= trial_code_i;
endmodule : comparator_model
`default_nettype wire

//--- test/sar_adc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// Handshake checker
module sar_adc_monitor
  import sar_adc_pkg::*;
#(parameter int unsigned BIT_CYC = 2) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic cs_n_i,
  input wire logic wr_n_i,
  input wire logic rd_n_i,
  input wire logic conversion_done_n_o,
  input wire logic [sar_adc_pkg::RES_BITS-1:0] result_bus_o,
  input wire logic result_bus_oe_o,
  input wire logic [sar_adc_pkg::RES_BITS-1:0] trial_code_o,
  input wire logic neg_ge_pos_i
);
  localparam int LIM = 8 * BIT_CYC + 4;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  wr_clear_a: assert property (!cs_n_i && !wr_n_i |=> conversion_done_n_o)
    else $error("flag not cleared by write");
  start_msb_a: assert property (
    !$past(wr_n_i) && !$past(cs_n_i) && wr_n_i && !cs_n_i |=> trial_code_o == MSB_ONLY)
    else $error("no start on write rise");
  conv_bound_a: assert property (
    !$past(wr_n_i) && !$past(cs_n_i) && wr_n_i && !cs_n_i |-> ##[1:LIM] !conversion_done_n_o)
    else $error("conversion too long");
  latch_first_a: assert property ($fell(conversion_done_n_o) |-> $stable(result_bus_o))
    else $error("result moved as flag fell");
  flag_hold_a: assert property (
    !conversion_done_n_o && (cs_n_i || rd_n_i && wr_n_i) |=> !conversion_done_n_o)
    else $error("flag dropped while unread");
  read_drive_a: assert property (!cs_n_i && !rd_n_i |=> result_bus_oe_o)
    else $error("bus not driven on read");
  rd_clear_a: assert property (
    !cs_n_i && !rd_n_i && !conversion_done_n_o |=> conversion_done_n_o)
    else $error("flag not cleared by read");
  cs_float_a: assert property (cs_n_i |=> !result_bus_oe_o)
    else $error("bus driven while deselected");
  zero_code_a: assert property (
    $fell(conversion_done_n_o) && neg_ge_pos_i |-> result_bus_o == ZERO_CODE)
    else $error("zero code not forced");
endmodule : sar_adc_monitor
`default_nettype wire

//--- test/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// Bench top
module tb;
  import sar_adc_pkg::*;
  logic clk_i = 0, resetn_i = 0, cs_n_i = 1, wr_n_i = 1, rd_n_i = 1, cmp_above_i;
  logic neg_ge_pos_i = 0, conversion_done_n_o, result_bus_oe_o;
  logic [7:0] result_bus_o, trial_code_o, vin = 8'h00;
  int miscompares = 0, n_checks = 0;
  always #50 clk_i = ~clk_i;
  sar_adc_host_handshake #(.BIT_CYC(2)) sar_adc_host_handshake_i (.clk_i(clk_i),
    .resetn_i(resetn_i), .cs_n_i(cs_n_i), .wr_n_i(wr_n_i), .rd_n_i(rd_n_i),
    .conversion_done_n_o(conversion_done_n_o), .result_bus_o(result_bus_o),
    .result_bus_oe_o(result_bus_oe_o), .trial_code_o(trial_code_o),
    .cmp_above_i(cmp_above_i), .neg_ge_pos_i(neg_ge_pos_i));
  comparator_model comparator_model_i (.trial_code_i(trial_code_o), .level_i(vin),
    .above_o(cmp_above_i));
  task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : chk
  task automatic tick(int n);
    repeat (n) @(posedge clk_i);
    #10;
  endtask : tick
  task automatic convert(logic [7:0] v);
    vin = v;
    cs_n_i = 0;
    wr_n_i = 0;
    tick(1);
    chk("flag after write", 8'h01, {7'h00, conversion_done_n_o});
    wr_n_i = 1;
    tick(1);
    chk("first trial", MSB_ONLY, trial_code_o);
    cs_n_i = 1;
    for (int i = 0; i < 20 && conversion_done_n_o !== 1'b0; i++) tick(1);
    chk("flag at end", 8'h00, {7'h00, conversion_done_n_o});
    tick(6); // Host settling wait
  endtask : convert
  task automatic read_expect(logic [7:0] exp);
    cs_n_i = 0;
    rd_n_i = 0;
    tick(1);
    chk("read flag and drive", 8'h03, {6'h00, conversion_done_n_o, result_bus_oe_o});
    chk("result", exp, result_bus_o);
    rd_n_i = 1;
    cs_n_i = 1;
    tick(1);
    chk("drive after read", 8'h00, {7'h00, result_bus_oe_o});
  endtask : read_expect
  task automatic conv_test();
    logic [7:0] vals[5] = '{8'h00, 8'hFF, 8'hA5, 8'h5A, 8'h80};
    foreach (vals[i]) begin
      convert(vals[i]);
      read_expect(vals[i]);
    end
    $display("conversion test ended");
  endtask : conv_test
  task automatic zero_test();
    neg_ge_pos_i = 1;
    convert(8'hFF);
    read_expect(ZERO_CODE);
    neg_ge_pos_i = 0;
    $display("zero code test ended");
  endtask : zero_test
  task automatic unread_test();
    convert(8'h3C);
    wr_n_i = 0;
    rd_n_i = 0;
    tick(2);
    chk("deselected strobes", 8'h00, {6'h00, conversion_done_n_o, result_bus_oe_o});
    wr_n_i = 1;
    rd_n_i = 1;
    tick(2);
    read_expect(8'h3C);
    $display("unread flag test ended");
  endtask : unread_test
  task automatic test_done();
    $display("checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done
  initial begin
    tick(16);
    resetn_i = 1;
    chk("reset result", RESULT_RST, result_bus_o);
    conv_test();
    zero_test();
    unread_test();
    test_done();
  end
  // Tests need a few hundred cycles; 20000 leaves wide margin
  initial begin
    #2_000_000;
    miscompares++;
    test_done();
  end
endmodule : tb
bind sar_adc_host_handshake sar_adc_monitor #(.BIT_CYC(BIT_CYC)) sar_adc_monitor_i (
  .clk_i(clk_i), .resetn_i(resetn_i), .cs_n_i(cs_n_i), .wr_n_i(wr_n_i), .rd_n_i(rd_n_i),
  .conversion_done_n_o(conversion_done_n_o), .result_bus_o(result_bus_o),
  .result_bus_oe_o(result_bus_oe_o), .trial_code_o(trial_code_o),
  .neg_ge_pos_i(neg_ge_pos_i));
`default_nettype wire
